// ---- design/fll_clock_generator_config.sv ----
// The AHB-Lite register port and the address map were decided locally.
`timescale 1ns/1ps
// Behaviour
// [R1] Multiplier code gives N = 4 + 2*code
// [R2] Divider code gives R = 2**code
// [R3] Self-clocked: output is oscillator over R
// [R4] Bypassed external: output is external over R
// [R5] Engaged internal: reference/7 *64 *N /R
// [R6] Engaged external: external *P *N /R
// [R7] Reset leaves self-clocked, about 8 MHz
// [R8] Self-clocked bus 4 MHz, filter extends
// [R9] Self-clocked: reference off, oscillator open loop
// [R10] Bypassed external: reference and oscillator off
// [R11] Mode field 11 selects engaged external
// [R12] Range bit selects prescale 64 or 1
// [R13] High-gain bit zero means low power
// [R14] Bit 5 requests external crystal reference
// [R15] Control one bit 0 reads zero
// [R16] Select bits zero raise loss interrupts
// [R17] Status one read-only, flag clears
// [R18] Software checks stable flag before timing work
// [R19] Filter twelve bits, loop adjusts it
// [R20] Trim written only for internal trimming
// [R21] Software picks smallest N and R
// [R22] Bus clock is output over two
// [R23] Mode field 01 selects engaged internal
module fll_clock_generator_config #(
    parameter logic [31:0] IRG_KHZ = 32'h0000_00f3
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [15:0] extRefKhz,
    input wire logic lossOfLock,
    input wire logic lossOfClock,
    input wire logic oscStable,
    output fll_clock_pkg::osc_ctrl_t oscCtrl,
    output logic [31:0] genOutKhz,
    output logic [31:0] busKhz,
    output logic [4:0] multFactor,
    output logic [7:0] divFactor,
    output logic [1:0] actualMode,
    output logic lossIrq,
    output logic lossResetReq
);

    // ==========================================================
    // Decode helpers
    function automatic logic [4:0] mult_of(input logic [2:0] code);
        mult_of = 5'h04 + {1'b0, code, 1'b0}; // [R1]
    endfunction : mult_of

    function automatic logic [7:0] div_of(input logic [2:0] code);
        div_of = 8'h01 << code; // [R2]
    endfunction : div_of

    // ==========================================================
    // Registers
    logic [7:0] ctrlOne;
    logic [7:0] ctrlTwo;
    logic [11:0] filter;
    logic [7:0] trim;
    logic flagLoss;
    logic flagLol;
    logic flagLoc;
    logic stableSeen;
    fll_clock_pkg::clk_mode_t mode;

    logic wrPend;
    logic [7:0] wrAddr;
    logic addrPhase;
    logic wrCtrlOne;
    logic wrCtrlTwo;
    logic wrFilter;
    logic wrTrim;
    logic wrStatus;
    logic [2:0] multCode;
    logic [2:0] divCode;
    logic [31:0] dcoKhz;
    logic [31:0] preDivKhz;
    logic [31:0] next_genOut;
    logic [31:0] loopFilter;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign addrPhase = hsel && hready && htrans[1];
    assign wrCtrlOne = wrPend && (wrAddr == fll_clock_pkg::OFS_CTRL_ONE);
    assign wrCtrlTwo = wrPend && (wrAddr == fll_clock_pkg::OFS_CTRL_TWO);
    assign wrFilter = wrPend && (wrAddr == fll_clock_pkg::OFS_FILTER);
    assign wrTrim = wrPend && (wrAddr == fll_clock_pkg::OFS_TRIM);
    assign wrStatus = wrPend && (wrAddr == fll_clock_pkg::OFS_STATUS_ONE);
    assign multCode = ctrlTwo[fll_clock_pkg::CTRL2_MULT_HI:fll_clock_pkg::CTRL2_MULT_LO];
    assign divCode = ctrlTwo[fll_clock_pkg::CTRL2_DIV_HI:fll_clock_pkg::CTRL2_DIV_LO];

    // ==========================================================
    // Bus address phase; zero wait states, writes land in data phase
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            wrPend <= 1'b0;
            wrAddr <= 8'h00;
        end
        else
        begin
            wrPend <= addrPhase && hwrite;
            wrAddr <= haddr;
        end
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            hrdata <= 32'h0000_0000;
        end
        else if (addrPhase && !hwrite)
        begin
            case (haddr)
                fll_clock_pkg::OFS_CTRL_ONE: hrdata <= {24'h000000, ctrlOne[7:1], 1'b0}; // [R15]
                fll_clock_pkg::OFS_CTRL_TWO: hrdata <= {24'h000000, ctrlTwo};
                fll_clock_pkg::OFS_FILTER: hrdata <= {20'h00000, filter}; // [R19]
                fll_clock_pkg::OFS_TRIM: hrdata <= {24'h000000, trim};
                fll_clock_pkg::OFS_STATUS_ONE:
                    hrdata <= {24'h000000, actualMode, 3'h0, flagLoc, flagLol, flagLoss};
                fll_clock_pkg::OFS_STATUS_TWO: hrdata <= {31'h00000000, stableSeen};
                fll_clock_pkg::OFS_FREQ: hrdata <= genOutKhz;
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // Control registers
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrlOne <= fll_clock_pkg::RST_CTRL_ONE; // [R7]
        end
        else if (wrCtrlOne)
        begin
            ctrlOne <= {hwdata[7:1], 1'b0}; // [R15]
        end
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrlTwo <= fll_clock_pkg::RST_CTRL_TWO;
        end
        else if (wrCtrlTwo)
        begin
            ctrlTwo <= hwdata[7:0];
        end
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            trim <= fll_clock_pkg::RST_TRIM;
        end
        else if (wrTrim)
        begin
            trim <= hwdata[7:0];
        end
    end

    // Loop owns the filter while engaged; software writes then are dropped
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            filter <= fll_clock_pkg::RST_FILTER;
        end
        else if (mode == fll_clock_pkg::MODE_ENG_INT || mode == fll_clock_pkg::MODE_ENG_EXT)
        begin
            filter <= loopFilter[11:0]; // [R19]
        end
        else if (wrFilter)
        begin
            filter <= hwdata[11:0]; // [R8]
        end
    end

    // ==========================================================
    // Mode selection; external modes need the crystal request set
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            mode <= fll_clock_pkg::MODE_SELF; // [R7]
        end
        else
        begin
            case (ctrlOne[fll_clock_pkg::CTRL1_MODE_HI:fll_clock_pkg::CTRL1_MODE_LO])
                fll_clock_pkg::CODE_ENG_INT: mode <= fll_clock_pkg::MODE_ENG_INT; // [R23]
                fll_clock_pkg::CODE_BYP_EXT:
                    mode <= ctrlOne[fll_clock_pkg::CTRL1_EXT_REQ] ?
                        fll_clock_pkg::MODE_BYP_EXT : fll_clock_pkg::MODE_SELF; // [R14]
                fll_clock_pkg::CODE_ENG_EXT:
                    mode <= ctrlOne[fll_clock_pkg::CTRL1_EXT_REQ] ?
                        fll_clock_pkg::MODE_ENG_EXT : fll_clock_pkg::MODE_SELF; // [R11]
                default: mode <= fll_clock_pkg::MODE_SELF;
            endcase
        end
    end

    always_comb
    begin
        case (mode)
            fll_clock_pkg::MODE_ENG_INT: actualMode = fll_clock_pkg::CODE_ENG_INT;
            fll_clock_pkg::MODE_BYP_EXT: actualMode = fll_clock_pkg::CODE_BYP_EXT;
            fll_clock_pkg::MODE_ENG_EXT: actualMode = fll_clock_pkg::CODE_ENG_EXT;
            default: actualMode = fll_clock_pkg::CODE_SELF;
        endcase
    end

    // ==========================================================
    // Oscillator power and configuration
    always_comb
    begin
        oscCtrl.irgOn = (mode == fll_clock_pkg::MODE_ENG_INT); // [R9] [R10]
        oscCtrl.dcoOn = (mode != fll_clock_pkg::MODE_BYP_EXT); // [R10]
        oscCtrl.dcoOpenLoop = (mode == fll_clock_pkg::MODE_SELF); // [R9]
        oscCtrl.oscHighGain = ctrlOne[fll_clock_pkg::CTRL1_HIGH_GAIN]; // [R13]
        oscCtrl.oscExtRequest = ctrlOne[fll_clock_pkg::CTRL1_EXT_REQ]; // [R14]
        oscCtrl.oscKeepOn = ctrlOne[fll_clock_pkg::CTRL1_KEEP_ON];
        oscCtrl.lossClockDisable = ctrlOne[fll_clock_pkg::CTRL1_LOC_DIS];
    end

    // ==========================================================
    // Frequency model; filter zero gives the 8 MHz start-up figure
    assign dcoKhz = fll_clock_pkg::DCO_BASE_KHZ + ({20'h00000, filter} << fll_clock_pkg::DCO_STEP_SHIFT);

    always_comb
    begin
        case (mode)
            fll_clock_pkg::MODE_ENG_INT:
                preDivKhz = (IRG_KHZ / fll_clock_pkg::IRG_DIVISOR) * fll_clock_pkg::PRESCALE_LOW
                    * {27'h0000000, mult_of(multCode)}; // [R5]
            fll_clock_pkg::MODE_ENG_EXT:
                preDivKhz = {16'h0000, extRefKhz}
                    * (ctrlOne[fll_clock_pkg::CTRL1_RANGE] ? 32'h0000_0001 : fll_clock_pkg::PRESCALE_LOW)
                    * {27'h0000000, mult_of(multCode)}; // [R6] [R12]
            fll_clock_pkg::MODE_BYP_EXT: preDivKhz = {16'h0000, extRefKhz}; // [R4]
            default: preDivKhz = dcoKhz; // [R3]
        endcase
        next_genOut = preDivKhz >> divCode; // [R2]
    end

    // Locked oscillator setting mirrored into the filter; clamped to 12 bits
    always_comb
    begin
        if (preDivKhz <= fll_clock_pkg::DCO_BASE_KHZ)
        begin
            loopFilter = 32'h0000_0000;
        end
        else if (((preDivKhz - fll_clock_pkg::DCO_BASE_KHZ) >> fll_clock_pkg::DCO_STEP_SHIFT)
            > 32'h0000_0fff)
        begin
            loopFilter = 32'h0000_0fff;
        end
        else
        begin
            loopFilter = (preDivKhz - fll_clock_pkg::DCO_BASE_KHZ) >> fll_clock_pkg::DCO_STEP_SHIFT;
        end
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            genOutKhz <= 32'h0000_0000;
            busKhz <= 32'h0000_0000;
            multFactor <= 5'h04;
            divFactor <= 8'h01;
        end
        else
        begin
            genOutKhz <= next_genOut;
            busKhz <= next_genOut >> 1; // [R22]
            multFactor <= mult_of(multCode); // [R1]
            divFactor <= div_of(divCode); // [R2]
        end
    end

    // ==========================================================
    // Loss events; an event in the clearing cycle still sets its flag
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            flagLol <= 1'b0;
            flagLoc <= 1'b0;
            flagLoss <= 1'b0;
        end
        else
        begin
            if (lossOfLock && !ctrlTwo[fll_clock_pkg::CTRL2_LOL_SEL])
                flagLol <= 1'b1; // [R16]
            else if (wrStatus && hwdata[fll_clock_pkg::STAT1_FLAG])
                flagLol <= 1'b0; // [R17]
            if (lossOfClock && !ctrlTwo[fll_clock_pkg::CTRL2_LOC_SEL]
                && !ctrlOne[fll_clock_pkg::CTRL1_LOC_DIS])
                flagLoc <= 1'b1; // [R16]
            else if (wrStatus && hwdata[fll_clock_pkg::STAT1_FLAG])
                flagLoc <= 1'b0; // [R17]
            if ((lossOfLock && !ctrlTwo[fll_clock_pkg::CTRL2_LOL_SEL])
                || (lossOfClock && !ctrlTwo[fll_clock_pkg::CTRL2_LOC_SEL]
                && !ctrlOne[fll_clock_pkg::CTRL1_LOC_DIS]))
                flagLoss <= 1'b1; // [R16]
            else if (wrStatus && hwdata[fll_clock_pkg::STAT1_FLAG])
                flagLoss <= 1'b0; // [R17]
        end
    end

    // Stable indication read by software before time-critical work
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            stableSeen <= 1'b0;
            lossResetReq <= 1'b0;
        end
        else
        begin
            stableSeen <= oscStable; // [R18]
            lossResetReq <= (lossOfLock && ctrlTwo[fll_clock_pkg::CTRL2_LOL_SEL])
                || (lossOfClock && ctrlTwo[fll_clock_pkg::CTRL2_LOC_SEL]
                && !ctrlOne[fll_clock_pkg::CTRL1_LOC_DIS]);
        end
    end

    assign lossIrq = flagLoss; // [R16]

    // ==========================================================
    // Checks
    AST_MULT_DECODE: assert property (@(posedge mclk) disable iff (!nrst) // [R1]
        ##1 multFactor == 5'h04 + {1'b0, $past(multCode), 1'b0})
        else $error("Multiplier factor wrong");

    AST_DIV_DECODE: assert property (@(posedge mclk) disable iff (!nrst) // [R2]
        ##1 divFactor == (8'h01 << $past(divCode)))
        else $error("Divider factor wrong");

    AST_SELF_FREQ: assert property (@(posedge mclk) disable iff (!nrst) // [R3]
        mode == fll_clock_pkg::MODE_SELF |=> genOutKhz == ($past(dcoKhz) >> $past(divCode)))
        else $error("Self-clocked output wrong");

    AST_BYP_FREQ: assert property (@(posedge mclk) disable iff (!nrst) // [R4]
        mode == fll_clock_pkg::MODE_BYP_EXT
        |=> genOutKhz == ({16'h0000, $past(extRefKhz)} >> $past(divCode)))
        else $error("Bypassed output wrong");

    AST_ENG_INT_FREQ: assert property (@(posedge mclk) disable iff (!nrst) // [R5]
        mode == fll_clock_pkg::MODE_ENG_INT && divCode == 3'h0 && multCode == 3'h0
        |=> genOutKhz == (IRG_KHZ / 32'h0000_0007) * 32'h0000_0100)
        else $error("Engaged internal output wrong");

    AST_ENG_EXT_FREQ: assert property (@(posedge mclk) disable iff (!nrst) // [R6]
        mode == fll_clock_pkg::MODE_ENG_EXT && ctrlOne[6] && divCode == 3'h0
        |=> genOutKhz == {16'h0000, $past(extRefKhz)} * {27'h0000000, $past(multFactor) + 5'h00}
        || $past(multCode) != $past(multCode, 2))
        else $error("Engaged external output wrong");

    AST_BUS_HALF: assert property (@(posedge mclk) disable iff (!nrst) // [R22]
        busKhz == (genOutKhz >> 1))
        else $error("Bus frequency not half");

    AST_SELF_POWER: assert property (@(posedge mclk) disable iff (!nrst) // [R9]
        mode == fll_clock_pkg::MODE_SELF |-> !oscCtrl.irgOn && oscCtrl.dcoOpenLoop)
        else $error("Self-clocked power wrong");

    AST_BYP_POWER: assert property (@(posedge mclk) disable iff (!nrst) // [R10]
        mode == fll_clock_pkg::MODE_BYP_EXT |-> !oscCtrl.irgOn && !oscCtrl.dcoOn)
        else $error("Bypassed power wrong");

    AST_ENG_EXT_SEL: assert property (@(posedge mclk) disable iff (!nrst) // [R11]
        ctrlOne[4:3] == 2'h3 && ctrlOne[5] |=> mode == fll_clock_pkg::MODE_ENG_EXT)
        else $error("Mode 11 not engaged external");

    AST_CTRL1_BIT0: assert property (@(posedge mclk) disable iff (!nrst) // [R15]
        addrPhase && !hwrite && haddr == fll_clock_pkg::OFS_CTRL_ONE |=> !hrdata[0])
        else $error("Control one bit 0 not zero");

    AST_LOSS_IRQ: assert property (@(posedge mclk) disable iff (!nrst) // [R16]
        lossOfLock && !ctrlTwo[7] |=> lossIrq ##1 (lossIrq || $past(wrStatus)))
        else $error("Loss interrupt missing");

endmodule : fll_clock_generator_config

// ---- design/fll_clock_pkg.sv ----
package fll_clock_pkg;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL_ONE = 8'h00;
    localparam logic [7:0] OFS_CTRL_TWO = 8'h04;
    localparam logic [7:0] OFS_FILTER = 8'h08;
    localparam logic [7:0] OFS_TRIM = 8'h0c;
    localparam logic [7:0] OFS_STATUS_ONE = 8'h10;
    localparam logic [7:0] OFS_STATUS_TWO = 8'h14;
    localparam logic [7:0] OFS_FREQ = 8'h18;

    // ==========================================================
    // Field positions
    localparam int CTRL1_HIGH_GAIN = 7;
    localparam int CTRL1_RANGE = 6;
    localparam int CTRL1_EXT_REQ = 5;
    localparam int CTRL1_MODE_HI = 4;
    localparam int CTRL1_MODE_LO = 3;
    localparam int CTRL1_KEEP_ON = 2;
    localparam int CTRL1_LOC_DIS = 1;
    localparam int CTRL2_LOL_SEL = 7;
    localparam int CTRL2_MULT_HI = 6;
    localparam int CTRL2_MULT_LO = 4;
    localparam int CTRL2_LOC_SEL = 3;
    localparam int CTRL2_DIV_HI = 2;
    localparam int CTRL2_DIV_LO = 0;
    localparam int STAT1_FLAG = 0;
    localparam int STAT1_LOL = 1;
    localparam int STAT1_LOC = 2;
    localparam int STAT2_STABLE = 0;
    localparam int FILTER_BITS = 12;

    // ==========================================================
    // Reset values and mode codes
    localparam logic [7:0] RST_CTRL_ONE = 8'h00;
    localparam logic [7:0] RST_CTRL_TWO = 8'h00;
    localparam logic [11:0] RST_FILTER = 12'h000;
    localparam logic [7:0] RST_TRIM = 8'h80;
    localparam logic [1:0] CODE_SELF = 2'h0;
    localparam logic [1:0] CODE_ENG_INT = 2'h1;
    localparam logic [1:0] CODE_BYP_EXT = 2'h2;
    localparam logic [1:0] CODE_ENG_EXT = 2'h3;

    // ==========================================================
    // Frequency constants, kHz
    localparam logic [31:0] IRG_DIVISOR = 32'h0000_0007;
    localparam logic [31:0] PRESCALE_LOW = 32'h0000_0040;
    localparam logic [31:0] DCO_BASE_KHZ = 32'h0000_1f40;
    localparam int DCO_STEP_SHIFT = 3;

    typedef enum logic [1:0] {MODE_SELF, MODE_ENG_INT, MODE_BYP_EXT, MODE_ENG_EXT} clk_mode_t;

    typedef struct packed {
        logic irgOn;
        logic dcoOn;
        logic dcoOpenLoop;
        logic oscHighGain;
        logic oscExtRequest;
        logic oscKeepOn;
        logic lossClockDisable;
    } osc_ctrl_t;

endpackage : fll_clock_pkg

// ---- verification/ext_ref_source.sv ----
`timescale 1ns/1ps
// ==========================================
// External reference source
module ext_ref_source #(
    parameter int STARTUP = 8
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic extRequest,
    output logic [15:0] extRefKhz,
    output logic lossOfLock,
    output logic lossOfClock,
    output logic oscStable
);
    int cnt;

    initial
    begin
        extRefKhz = 16'h0fa0;
        lossOfLock = 1'b0;
        lossOfClock = 1'b0;
    end

    // A crystal needs time to start, so stable comes late after each request
    always @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt <= 0;
            oscStable <= 1'b0;
        end
        else
        begin
            cnt <= extRequest ? cnt + 1 : 0;
            oscStable <= extRequest && (cnt >= STARTUP);
        end
    end

    task setFreq(input logic [15:0] f);
        @(posedge mclk);
        extRefKhz <= f;
    endtask : setFreq

    // One-cycle loss event, lock or clock
    task pulse(input logic clockLoss);
        @(posedge mclk);
        lossOfClock <= clockLoss;
        lossOfLock <= !clockLoss;
        @(posedge mclk);
        lossOfClock <= 1'b0;
        lossOfLock <= 1'b0;
    endtask : pulse
endmodule : ext_ref_source

// ---- verification/fll_clock_generator_config_test.sv ----
`timescale 1ns/1ps
module fll_clock_generator_config_test;
    logic mclk, nrst, hsel, hwrite, hreadyout, hresp, lossIrq, lossResetReq;
    logic lossOfLock, lossOfClock, oscStable;
    logic [7:0] haddr, divFactor;
    logic [1:0] htrans, actualMode;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, genOutKhz, busKhz, rd;
    logic [15:0] extRefKhz;
    logic [4:0] multFactor;
    fll_clock_pkg::osc_ctrl_t oscCtrl;
    int num_errors = 0;
    int n_tests = 0;

    fll_clock_generator_config uut (.mclk(mclk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .extRefKhz(extRefKhz),
        .lossOfLock(lossOfLock), .lossOfClock(lossOfClock), .oscStable(oscStable),
        .oscCtrl(oscCtrl), .genOutKhz(genOutKhz), .busKhz(busKhz), .multFactor(multFactor),
        .divFactor(divFactor), .actualMode(actualMode), .lossIrq(lossIrq),
        .lossResetReq(lossResetReq));

    ext_ref_source src (.mclk(mclk), .nrst(nrst), .extRequest(oscCtrl.oscExtRequest),
        .extRefKhz(extRefKhz), .lossOfLock(lossOfLock), .lossOfClock(lossOfClock),
        .oscStable(oscStable));

    always #20 mclk = ~mclk;

    // ==========================================
    // Shared tasks
    task stop_test;
        $display("Checks %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : stop_test

    task check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task settle(input int n);
        repeat (n) @(posedge mclk);
    endtask : settle

    // Bounded wait for hready at a rising edge
    task waitReady;
        int i;
        i = 0;
        do
        begin
            @(posedge mclk);
            i++;
        end
        while (hreadyout !== 1'b1 && i < 50);
        if (hreadyout !== 1'b1)
        begin
            num_errors++;
            $display("Error at %0t: bus never ready", $time);
            stop_test();
        end
    endtask : waitReady

    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hsize <= 3'h2;
        hwrite <= w;
        haddr <= a;
        waitReady();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hsize <= 3'h0;
        hwdata <= d;
        waitReady();
        rd = hrdata;
    endtask : xfer

    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    task rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        xfer(1'b0, a, 32'h0);
        check(rd, exp, what);
    endtask : rdchk

    // ==========================================
    // Scenarios
    task test_reset;
        check(genOutKhz, 32'h0000_1f40, "reset output");
        check(busKhz, 32'h0000_0fa0, "reset bus");
        check(32'(oscCtrl), 32'h30, "reset osc control");
        check(32'(actualMode), 32'h0, "reset mode");
        check(32'(hresp), 32'h0, "okay response");
        rdchk(fll_clock_pkg::OFS_CTRL_ONE, 32'h0, "ctrl one reset");
        rdchk(fll_clock_pkg::OFS_TRIM, 32'h80, "trim reset");
        rdchk(8'h1c, 32'h0, "unmapped read");
        $display("test_reset done");
    endtask : test_reset

    task test_decode;
        logic [2:0] c;
        for (int i = 0; i < 8; i++)
        begin
            c = i[2:0];
            wr(fll_clock_pkg::OFS_CTRL_TWO, 32'({1'b0, c, 1'b0, c}));
            settle(4);
            check(32'(multFactor), 32'(4 + 2 * i), "multiplier");
            check(32'(divFactor), 32'(1 << i), "divider");
            check(genOutKhz, 32'h1f40 >> i, "self output");
            check(busKhz, (32'h1f40 >> i) >> 1, "bus clock");
        end
        $display("test_decode done");
    endtask : test_decode

    task test_filter;
        wr(fll_clock_pkg::OFS_CTRL_TWO, 32'h0);
        wr(fll_clock_pkg::OFS_FILTER, 32'h0000_ffff);
        settle(4);
        rdchk(fll_clock_pkg::OFS_FILTER, 32'h0fff, "filter width");
        check(genOutKhz, 32'h9f38, "filter raised output");
        check(busKhz, 32'h4f9c, "filter raised bus");
        wr(fll_clock_pkg::OFS_FILTER, 32'h0);
        $display("test_filter done");
    endtask : test_filter

    task test_modes;
        src.setFreq(16'h0fa0);
        wr(fll_clock_pkg::OFS_CTRL_ONE, 32'hf9);
        wr(fll_clock_pkg::OFS_CTRL_TWO, 32'h30);
        settle(4);
        check(32'(actualMode), 32'h3, "engaged external mode");
        check(genOutKhz, 32'h9c40, "high range output");
        check(32'(oscCtrl.oscHighGain), 32'h1, "high gain");
        check(32'(oscCtrl.oscExtRequest), 32'h1, "crystal request");
        rdchk(fll_clock_pkg::OFS_CTRL_ONE, 32'hf8, "bit 0 reads zero");
        src.setFreq(16'h0020);
        wr(fll_clock_pkg::OFS_CTRL_ONE, 32'hb8);
        wr(fll_clock_pkg::OFS_CTRL_TWO, 32'h00);
        settle(4);
        check(genOutKhz, 32'h2000, "low range output");
        src.setFreq(16'h0fa0);
        wr(fll_clock_pkg::OFS_CTRL_ONE, 32'hb0);
        wr(fll_clock_pkg::OFS_CTRL_TWO, 32'h01);
        settle(4);
        check(32'(actualMode), 32'h2, "bypassed mode");
        check(genOutKhz, 32'h07d0, "bypassed output");
        check(32'({oscCtrl.irgOn, oscCtrl.dcoOn}), 32'h0, "bypassed power");
        wr(fll_clock_pkg::OFS_CTRL_ONE, 32'h10);
        settle(4);
        check(32'(actualMode), 32'h0, "no crystal falls back");
        wr(fll_clock_pkg::OFS_CTRL_ONE, 32'ha8);
        wr(fll_clock_pkg::OFS_CTRL_TWO, 32'h31);
        settle(4);
        check(32'(actualMode), 32'h1, "engaged internal mode");
        check(genOutKhz, 32'h2a80, "engaged internal output");
        check(32'(oscCtrl.irgOn), 32'h1, "reference on");
        wr(fll_clock_pkg::OFS_CTRL_TWO, 32'h00);
        settle(4);
        check(genOutKhz, 32'h2200, "engaged internal N 4 R 1");
        $display("test_modes done");
    endtask : test_modes

    task test_loss;
        int n;
        src.pulse(1'b0);
        settle(3);
        check(32'(lossIrq), 32'h1, "lock loss request");
        xfer(1'b0, fll_clock_pkg::OFS_STATUS_ONE, 32'h0);
        check(rd & 32'h7, 32'h3, "lock loss flags");
        wr(fll_clock_pkg::OFS_STATUS_ONE, 32'h1);
        settle(2);
        check(32'(lossIrq), 32'h0, "flag cleared");
        src.pulse(1'b1);
        settle(3);
        xfer(1'b0, fll_clock_pkg::OFS_STATUS_ONE, 32'h0);
        check(rd & 32'h7, 32'h5, "clock loss flags");
        wr(fll_clock_pkg::OFS_STATUS_ONE, 32'h1);
        wr(fll_clock_pkg::OFS_CTRL_TWO, 32'hb1);
        src.pulse(1'b0);
        n = 0;
        repeat (6)
        begin
            @(posedge mclk);
            if (lossResetReq === 1'b1)
                n++;
        end
        check(32'(n), 32'h1, "reset select pulse");
        check(32'(lossIrq), 32'h0, "no request when reset selected");
        xfer(1'b0, fll_clock_pkg::OFS_STATUS_TWO, 32'h0);
        check(rd & 32'h1, 32'h1, "oscillator stable");
        $display("test_loss done");
    endtask : test_loss

    initial
    begin
        mclk = 1'b0;
        nrst = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        haddr = 8'h00;
        htrans = 2'h0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        settle(2);
        test_reset();
        test_decode();
        test_filter();
        test_modes();
        test_loss();
        stop_test();
    end
endmodule : fll_clock_generator_config_test
